// ==== hdl/msir_pkg.sv ====
// Purpose: Constants and types for the MAC status and interrupt registers
// Assumes: Byte addresses on a 32-bit register port
// Notes: Flag positions are shared by interrupt status, enable, disable and mask
package msir_pkg;
  localparam logic [31:0] RSR_ADDR = 32'hfffbc020;
  localparam logic [31:0] ISR_ADDR = 32'hfffbc024;
  localparam logic [31:0] IER_ADDR = 32'hfffbc028;
  localparam logic [31:0] IDR_ADDR = 32'hfffbc02c;
  localparam logic [31:0] IMR_ADDR = 32'hfffbc030;
  localparam int NO_BUFFER_FLAG = 0;
  localparam int FRAME_RECEIVED_FLAG = 1;
  localparam int RX_OVERRUN_STATUS = 2;
  localparam int MGMT_DONE_IRQ = 0;
  localparam int RX_COMPLETE_IRQ = 1;
  localparam int RX_OWNED_DESC_IRQ = 2;
  localparam int TX_OWNED_DESC_IRQ = 3;
  localparam int TX_UNDERRUN_IRQ = 4;
  localparam int RETRY_LIMIT_IRQ = 5;
  localparam int TX_EXHAUSTED_IRQ = 6;
  localparam int TX_COMPLETE_IRQ = 7;
  localparam int RX_OVERRUN_IRQ = 10;
  localparam int BUS_ERROR_IRQ = 11;
  localparam int PAUSE_RX_IRQ = 12;
  localparam int PAUSE_ZERO_IRQ = 13;
  localparam int WAKE_EVENT_IRQ = 14;
  localparam logic [31:0] RSR_BITS = 32'h00000007;
  localparam logic [31:0] ISR_BITS = 32'h00007cff;
  localparam logic [31:0] RSR_RESET = 32'h00000000;
  localparam logic [31:0] ISR_RESET = 32'h00000000;
  localparam logic [31:0] IMR_RESET = 32'h00000000;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
  typedef struct packed {
    logic mgmt_done;
    logic rx_frame_stored;
    logic rx_desc_owned;
    logic rx_desc_valid;
    logic rx_frame_start;
    logic rx_overrun;
    logic tx_desc_owned;
    logic tx_late;
    logic tx_owned_midframe;
    logic tx_queue_written;
    logic retry_limit;
    logic tx_exhausted;
    logic tx_done;
    logic bus_error;
    logic pause_rx;
    logic pause_zero;
  } msir_evt_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } msir_req_t;
  typedef enum logic [0:0] {RXF_READY, RXF_WAIT} msir_rxf_t;
endpackage

// ==== hdl/msir_regs.sv ====
// Purpose: Receive status, interrupt status and interrupt mask registers
// Assumes: Event inputs are one-cycle pulses on mclk; wake input is async
// Notes: Read data appear in the cycle after the read strobe only
`timescale 1ns/10ps
`default_nettype none
module msir_regs (
  input wire logic mclk,
  input wire logic rst,
  input wire msir_pkg::msir_req_t req,
  output logic [31:0] rdata,
  input wire msir_pkg::msir_evt_t ev,
  input wire logic wake_in,
  output logic rx_refetch_req,
  output logic rx_buf_recover,
  output logic irq
);
  import msir_pkg::*;

  logic [31:0] rsr_r, rsr_nxt, isr_r, isr_nxt, imr_r, imr_nxt;
  logic [31:0] rdata_r, rdata_nxt, rsr_set, isr_set;
  logic irq_r, irq_nxt, refetch_r, refetch_nxt, recover_r, recover_nxt;
  logic wr_rsr, rd_isr, wr_ier, wr_idr;
  msir_rxf_t rxf_r, rxf_nxt;
  logic wake_hold_r, wake_hold_nxt, wake_s1_r, wake_s2_r, wake_s3_r;

  assign rdata = rdata_r;
  assign irq = irq_r;
  assign rx_refetch_req = refetch_r;
  assign rx_buf_recover = recover_r;

  always_comb begin
    wr_rsr = 1'b0;
    rd_isr = 1'b0;
    wr_ier = 1'b0;
    wr_idr = 1'b0;
    if (req.addr == RSR_ADDR) begin
      wr_rsr = req.wr;
    end else if (req.addr == ISR_ADDR) begin
      rd_isr = req.rd;
    end else if (req.addr == IER_ADDR) begin
      wr_ier = req.wr;
    end else if (req.addr == IDR_ADDR) begin
      wr_idr = req.wr;
    end
  end

  // Unclocked capture so a wake survives a stopped clock
  always_comb begin
    wake_hold_nxt = wake_hold_r;
    if (wake_s2_r) begin
      wake_hold_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge wake_in) begin
    if (wake_in) begin
      wake_hold_r <= 1'b1;
    end else if (rst) begin
      wake_hold_r <= 1'b0;
    end else begin
      wake_hold_r <= wake_hold_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
      wake_s3_r <= 1'b0;
    end else begin
      wake_s1_r <= wake_hold_r;
      wake_s2_r <= wake_s1_r;
      wake_s3_r <= wake_s2_r;
    end
  end

  always_comb begin
    rsr_set = ZERO_WORD;
    rsr_set[NO_BUFFER_FLAG] = ev.rx_desc_owned;
    rsr_set[FRAME_RECEIVED_FLAG] = ev.rx_frame_stored;
    rsr_set[RX_OVERRUN_STATUS] = ev.rx_overrun;
    rsr_nxt = rsr_r & ~(wr_rsr ? req.wdata : ZERO_WORD);
    rsr_nxt = (rsr_nxt | rsr_set) & RSR_BITS;
  end

  always_comb begin
    isr_set = ZERO_WORD;
    isr_set[MGMT_DONE_IRQ] = ev.mgmt_done;
    isr_set[RX_COMPLETE_IRQ] = ev.rx_frame_stored;
    isr_set[RX_OWNED_DESC_IRQ] = ev.rx_desc_owned;
    isr_set[TX_OWNED_DESC_IRQ] = ev.tx_desc_owned;
    isr_set[TX_UNDERRUN_IRQ] = ev.tx_late | ev.tx_owned_midframe | ev.tx_queue_written;
    isr_set[RETRY_LIMIT_IRQ] = ev.retry_limit;
    isr_set[TX_EXHAUSTED_IRQ] = ev.tx_exhausted;
    isr_set[TX_COMPLETE_IRQ] = ev.tx_done;
    isr_set[RX_OVERRUN_IRQ] = ev.rx_overrun;
    isr_set[BUS_ERROR_IRQ] = ev.bus_error;
    isr_set[TX_UNDERRUN_IRQ] = isr_set[TX_UNDERRUN_IRQ] | ev.bus_error;
    isr_set[PAUSE_RX_IRQ] = ev.pause_rx;
    isr_set[PAUSE_ZERO_IRQ] = ev.pause_zero;
    isr_set[WAKE_EVENT_IRQ] = wake_s2_r & ~wake_s3_r;
    isr_nxt = ((rd_isr ? ZERO_WORD : isr_r) | isr_set) & ISR_BITS;
  end

  always_comb begin
    imr_nxt = imr_r;
    if (wr_ier) begin
      imr_nxt = imr_r | req.wdata;
    end
    if (wr_idr) begin
      imr_nxt = imr_r & ~req.wdata;
    end
    imr_nxt = imr_nxt & ISR_BITS;
    irq_nxt = |(isr_nxt & imr_nxt);
  end

  // Unmapped and write-only addresses read as zero
  always_comb begin
    rdata_nxt = ZERO_WORD;
    if (req.rd) begin
      if (req.addr == RSR_ADDR) begin
        rdata_nxt = rsr_r;
      end else if (req.addr == ISR_ADDR) begin
        rdata_nxt = isr_r;
      end else if (req.addr == IMR_ADDR) begin
        rdata_nxt = imr_r;
      end
    end
  end

  always_comb begin
    rxf_nxt = rxf_r;
    refetch_nxt = 1'b0;
    recover_nxt = ev.rx_overrun;
    case (rxf_r)
      RXF_READY: begin
        if (ev.rx_desc_owned) begin
          rxf_nxt = RXF_WAIT;
        end
      end
      RXF_WAIT: begin
        if (ev.rx_desc_valid) begin
          rxf_nxt = RXF_READY;
        end else if (ev.rx_frame_start) begin
          refetch_nxt = 1'b1;
        end
      end
      default: begin
        rxf_nxt = RXF_READY;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rsr_r <= RSR_RESET;
      isr_r <= ISR_RESET;
      imr_r <= IMR_RESET;
      rdata_r <= ZERO_WORD;
      irq_r <= 1'b0;
      rxf_r <= RXF_READY;
      refetch_r <= 1'b0;
      recover_r <= 1'b0;
    end else begin
      rsr_r <= rsr_nxt;
      isr_r <= isr_nxt;
      imr_r <= imr_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
      rxf_r <= rxf_nxt;
      refetch_r <= refetch_nxt;
      recover_r <= recover_nxt;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  no_buffer_set_a: assert property (ev.rx_desc_owned |=> rsr_r[NO_BUFFER_FLAG])
    else $error("no buffer flag not set");
  refetch_frame_a: assert property (
    rxf_r == RXF_WAIT && !ev.rx_desc_valid && ev.rx_frame_start |=> rx_refetch_req)
    else $error("no refetch at frame start");
  refetch_again_a: assert property (
    ev.rx_desc_owned ##1 (ev.rx_desc_owned && wr_rsr) |=> rsr_r[NO_BUFFER_FLAG])
    else $error("repeat failure lost");
  frame_recv_a: assert property (ev.rx_frame_stored |=> rsr_r[FRAME_RECEIVED_FLAG])
    else $error("frame received flag missing");
  overrun_recover_a: assert property (
    ev.rx_overrun |=> rsr_r[RX_OVERRUN_STATUS] && rx_buf_recover)
    else $error("overrun not flagged or recovered");
  status_w1c_a: assert property (
    wr_rsr && rsr_set == ZERO_WORD |=>
      rsr_r == ($past(rsr_r) & ~$past(req.wdata)))
    else $error("receive status write wrong");
  status_hold_a: assert property (
    rsr_set == ZERO_WORD |=> (rsr_r & ~$past(rsr_r)) == ZERO_WORD)
    else $error("receive status set without event");
  isr_read_clr_a: assert property (
    rd_isr && isr_set == ZERO_WORD ##1 isr_set == ZERO_WORD |=> isr_r == ZERO_WORD)
    else $error("interrupt status not cleared on read");
  mgmt_done_a: assert property (ev.mgmt_done |=> isr_r[MGMT_DONE_IRQ])
    else $error("mgmt done missing");
  rx_comp_a: assert property (ev.rx_frame_stored |=> isr_r[RX_COMPLETE_IRQ])
    else $error("rx complete missing");
  owned_desc_a: assert property (
    ev.rx_desc_owned && ev.tx_desc_owned |=>
      isr_r[RX_OWNED_DESC_IRQ] && isr_r[TX_OWNED_DESC_IRQ])
    else $error("owned descriptor flags missing");
  underrun_a: assert property (
    ev.tx_late || ev.bus_error || ev.tx_owned_midframe || ev.tx_queue_written
      |=> isr_r[TX_UNDERRUN_IRQ])
    else $error("tx underrun missing");
  exhausted_a: assert property (ev.tx_exhausted |=> isr_r[TX_EXHAUSTED_IRQ])
    else $error("tx exhausted missing");
  tx_comp_a: assert property (ev.tx_done |=> isr_r[TX_COMPLETE_IRQ])
    else $error("tx complete missing");
  overrun_irq_a: assert property (
    $rose(rsr_r[RX_OVERRUN_STATUS]) |-> isr_r[RX_OVERRUN_IRQ])
    else $error("overrun irq missing");
  bus_err_a: assert property (ev.bus_error |=> isr_r[BUS_ERROR_IRQ])
    else $error("bus error irq missing");
  pause_rx_a: assert property (ev.pause_rx |=> isr_r[PAUSE_RX_IRQ])
    else $error("pause rx irq missing");
  pause_zero_a: assert property (ev.pause_zero |=> isr_r[PAUSE_ZERO_IRQ])
    else $error("pause zero irq missing");
  wake_flag_a: assert property (
    wake_hold_r && !wake_s1_r && !wake_s2_r |-> ##[1:3] isr_r[WAKE_EVENT_IRQ])
    else $error("wake irq missing");
  enable_set_a: assert property (
    wr_ier |=> (imr_r & $past(req.wdata) & ISR_BITS) == ($past(req.wdata) & ISR_BITS))
    else $error("enable write ignored");
  disable_clr_a: assert property (
    wr_idr |=> (imr_r & $past(req.wdata)) == ZERO_WORD)
    else $error("disable write ignored");
  mask_read_a: assert property (
    req.rd && req.addr == IMR_ADDR |=> rdata == $past(imr_r))
    else $error("mask readback wrong");
  irq_level_a: assert property (irq == |(isr_r & imr_r))
    else $error("interrupt output wrong");

  cover_refetch_c: cover property (ev.rx_desc_owned ##[1:8] rx_refetch_req);
  cover_irq_c: cover property (wr_ier ##[1:8] irq ##1 rd_isr);
  cover_set_clr_c: cover property (rd_isr && isr_set != ZERO_WORD);
  cover_wake_c: cover property ($rose(isr_r[WAKE_EVENT_IRQ]));
endmodule // msir_regs
`default_nettype wire

// ==== verif/tb_mac_status_interrupt_regs.sv ====
// Purpose: Self-checking bench for the MAC status and interrupt registers
// Assumes: Register port with read data one cycle after the read strobe
// Notes: Random events and masks from a fixed seed, directed corners first
`timescale 1ns/10ps
`default_nettype none
module tb_mac_status_interrupt_regs;
  import msir_pkg::*;
  logic mclk, rst, wake_in, rx_refetch_req, rx_buf_recover, irq;
  msir_req_t req;
  msir_evt_t ev;
  logic [31:0] rdata, mask_e, isr_e, rsr_e, m, d;
  logic [15:0] v;
  int n_mismatch, num_checks, i;

  msir_regs u_dut (.mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .ev(ev),
    .wake_in(wake_in), .rx_refetch_req(rx_refetch_req),
    .rx_buf_recover(rx_buf_recover), .irq(irq));

  always #4 mclk = ~mclk;

  task automatic wrap_up();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(logic [31:0] a, logic [31:0] dat);
    req.addr <= a;
    req.wdata <= dat;
    req.wr <= 1'b1;
    @(posedge mclk);
    req.wr <= 1'b0;
    // Let the strobe drop before a following write raises it again
    #1;
  endtask

  // Also ends any event pulse launched beside the read
  task automatic rd(logic [31:0] a, logic [31:0] exp, string name);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge mclk);
    req.rd <= 1'b0;
    ev <= '0;
    #1;
    chk(name, rdata, exp);
  endtask

  task automatic pulse(logic [15:0] p);
    ev <= msir_evt_t'(p);
    @(posedge mclk);
    ev <= '0;
    #1;
  endtask

  function automatic logic [31:0] isr_of(logic [15:0] p);
    msir_evt_t e;
    e = msir_evt_t'(p);
    return {17'h0, 1'b0, e.pause_zero, e.pause_rx, e.bus_error, e.rx_overrun, 2'b00,
      e.tx_done, e.tx_exhausted, e.retry_limit,
      e.tx_late | e.tx_owned_midframe | e.tx_queue_written | e.bus_error,
      e.tx_desc_owned, e.rx_desc_owned, e.rx_frame_stored, e.mgmt_done};
  endfunction

  function automatic logic [31:0] rsr_of(logic [15:0] p);
    msir_evt_t e;
    e = msir_evt_t'(p);
    return {29'h0, e.rx_overrun, e.rx_frame_stored, e.rx_desc_owned};
  endfunction

  initial begin
    void'($urandom(32'h01a74b85));
    mclk = 1'b0;
    rst = 1'b1;
    req = '0;
    ev = '0;
    wake_in = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    mask_e = 32'h0;
    isr_e = 32'h0;
    rsr_e = 32'h0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(RSR_ADDR, RSR_RESET, "rsr_reset");
    rd(ISR_ADDR, ISR_RESET, "isr_reset");
    rd(IMR_ADDR, IMR_RESET, "imr_reset");
    rd(IER_ADDR, ZERO_WORD, "ier_read");
    rd(IMR_ADDR + 32'h10, ZERO_WORD, "unmapped");
    // Refetch only while waiting on a processor-owned descriptor
    pulse(16'h2000);
    pulse(16'h0800);
    chk("refetch", {31'h0, rx_refetch_req}, 32'h1);
    @(posedge mclk);
    #1;
    chk("refetch_end", {31'h0, rx_refetch_req}, 32'h0);
    wr(RSR_ADDR, 32'h1);
    rd(RSR_ADDR, 32'h0, "rsr_clr");
    pulse(16'h2000);
    rd(RSR_ADDR, 32'h1, "rsr_again");
    rd(ISR_ADDR, 32'h4, "isr_rxown");
    pulse(16'h1000);
    pulse(16'h0800);
    chk("refetch_idle", {31'h0, rx_refetch_req}, 32'h0);
    pulse(16'h0400);
    chk("recover", {31'h0, rx_buf_recover}, 32'h1);
    wr(RSR_ADDR, 32'h0);
    rd(RSR_ADDR, 32'h5, "rsr_w0");
    wr(RSR_ADDR, 32'h5);
    rd(RSR_ADDR, 32'h0, "rsr_w1");
    rd(ISR_ADDR, 32'h400, "isr_ovr");
    // Wake path is slow through its synchroniser, so wait on irq
    wr(IER_ADDR, 32'h4000);
    wake_in <= 1'b1;
    @(posedge mclk);
    wake_in <= 1'b0;
    for (i = 0; i < 8 && irq !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    chk("wake_irq", {31'h0, irq}, 32'h1);
    rd(ISR_ADDR, 32'h4000, "isr_wake");
    chk("irq_clr", {31'h0, irq}, 32'h0);
    wr(IDR_ADDR, 32'h4000);
    // Event in the read cycle must survive the clear
    ev <= msir_evt_t'(16'h0008);
    rd(ISR_ADDR, 32'h0, "isr_race");
    rd(ISR_ADDR, 32'h80, "isr_keep");
    wr(IMR_ADDR, 32'hffffffff);
    rd(IMR_ADDR, 32'h0, "imr_ro");
    for (int k = 0; k < 40; k++) begin
      m = $urandom;
      d = $urandom & $urandom;
      wr(IER_ADDR, m);
      wr(IDR_ADDR, d);
      mask_e = (mask_e | m) & ~d & ISR_BITS;
      rd(IMR_ADDR, mask_e, "imr");
      v = 16'($urandom);
      pulse(v);
      isr_e = isr_e | isr_of(v);
      rsr_e = rsr_e | rsr_of(v);
      if ($urandom % 2 == 1) begin
        v = 16'($urandom);
        pulse(v);
        isr_e = isr_e | isr_of(v);
        rsr_e = rsr_e | rsr_of(v);
      end
      chk("irq", {31'h0, irq}, {31'h0, |(isr_e & mask_e)});
      rd(ISR_ADDR, isr_e, "isr");
      isr_e = 32'h0;
      m = $urandom;
      wr(RSR_ADDR, m);
      rsr_e = rsr_e & ~m;
      rd(RSR_ADDR, rsr_e, "rsr");
      chk("irq_low", {31'h0, irq}, 32'h0);
    end
    wrap_up();
  end
endmodule // tb_mac_status_interrupt_regs
`default_nettype wire
